// file: bench/cpu_side_model.sv
// Model of the CPU reset logic that counts watchdog reset pulses.
// Assumes status comes straight from the block.
`timescale 1ns/100ps
module cpu_side_model import timebase_watch_pkg::*; (
    input wire logic clock,
    input wire timer_status_t status,
    output int reset_count
);
    logic seen_ff = 1'b0;
    initial reset_count = 0;
    // Counts each CPU reset pulse as one restart.
    always @(posedge clock) begin
        seen_ff <= status.cpu_reset;
        if (status.cpu_reset && !seen_ff)
            reset_count <= reset_count + 1;
    end
endmodule // cpu_side_model

// file: bench/timebase_watch_chk.sv
// Assertion checker for the timebase, watch timer and watchdog block.
// Assumes it is bound to the block top and sees only its ports.
`timescale 1ns/100ps
module timer_chk import timebase_watch_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic base_x2_tick,
    input wire logic sub_tick,
    input wire logic sub_run,
    input wire timer_cfg_t cfg,
    input wire timer_cmd_t cmd,
    input wire timer_status_t status,
    input wire logic [3:0] tb_taps
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    property p_len; $rose(status.cpu_reset) |-> status.cpu_reset [*4]
        ##1 !status.cpu_reset; endproperty
    a_len: assert property (p_len)
        else $error("cpu reset pulse length wrong");
    property p_cause; $rose(status.cpu_reset) |-> $past(status.wd_active);
    endproperty
    a_cause: assert property (p_cause)
        else $error("cpu reset without active watchdog");
    property p_excl; status.cpu_reset |-> !status.wd_active; endproperty
    a_excl: assert property (p_excl)
        else $error("watchdog active during cpu reset");
    property p_start; cmd.wd_start && !status.wd_active && !status.cpu_reset
        |=> status.wd_active; endproperty
    a_start: assert property (p_start)
        else $error("watchdog did not start");
    property p_act; $rose(status.wd_active) |-> $past(cmd.wd_start);
    endproperty
    a_act: assert property (p_act)
        else $error("watchdog started by itself");
    property p_tbh; status.tb_irq && !cmd.tb_clear |=> status.tb_irq;
    endproperty
    a_tbh: assert property (p_tbh)
        else $error("timebase flag dropped");
    property p_wth; status.wt_irq && !cmd.wt_clear |=> status.wt_irq;
    endproperty
    a_wth: assert property (p_wth)
        else $error("watch flag dropped");
    property p_stab; status.stab_done && !cmd.stab_restart
        |=> status.stab_done; endproperty
    a_stab: assert property (p_stab)
        else $error("stabilization mark dropped");
    property p_tap; $rose(status.tb_irq) |-> tb_taps[cfg.tb_interval_sel];
    endproperty
    a_tap: assert property (p_tap)
        else $error("timebase flag without selected tap");
endmodule // timer_chk
bind timebase_watch_watchdog timer_chk u_timer_chk (.clock(clock),
    .reset(reset), .base_x2_tick(base_x2_tick), .sub_tick(sub_tick),
    .sub_run(sub_run), .cfg(cfg), .cmd(cmd), .status(status),
    .tb_taps(tb_taps));

// file: bench/timebase_watch_watchdog_tb.sv
// Self-checking bench for the timebase, watch timer and watchdog block.
// Assumes the block, checker and CPU side model are compiled first.
`timescale 1ns/100ps
module timebase_watch_watchdog_tb import timebase_watch_pkg::*;;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic base_x2_tick = 1'b0;
    logic sub_tick = 1'b0;
    logic sub_run = 1'b0;
    timer_cfg_t cfg = '0;
    timer_cmd_t cmd = '0;
    timer_status_t status;
    logic [3:0] tb_taps;
    int reset_count;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    always #10 clock = ~clock;
    timebase_watch_watchdog u_timebase_watch_watchdog (.clock(clock),
        .reset(reset), .base_x2_tick(base_x2_tick), .sub_tick(sub_tick),
        .sub_run(sub_run), .cfg(cfg), .cmd(cmd), .status(status),
        .tb_taps(tb_taps));
    cpu_side_model u_cpu_side_model (.clock(clock), .status(status),
        .reset_count(reset_count));
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            bad_count = bad_count + 1;
            give_verdict;
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Gives n rising edges on the chosen tick pins, two cycles per level.
    task step(input int n, input logic b, input logic s);
        repeat (n) begin
            @(negedge clock);
            base_x2_tick = b;
            sub_tick = s;
            repeat (2) @(negedge clock);
            base_x2_tick = 1'b0;
            sub_tick = 1'b0;
            @(negedge clock);
        end
        repeat (6) @(negedge clock);
    endtask
    task pulse(input timer_cmd_t c);
        @(negedge clock);
        cmd = c;
        @(negedge clock);
        cmd = '0;
    endtask
    task t_reset;
        chk({7'h00, status, tb_taps}, 16'h0000);
        $display("test reset done");
    endtask
    task t_watch;
        step(100, 1'b0, 1'b1);
        chk(16'(status.wt_irq), 16'h0000);
        sub_run = 1'b1;
        step(511, 1'b0, 1'b1);
        chk(16'(status.wt_irq), 16'h0000);
        step(1, 1'b0, 1'b1);
        chk(16'(status.wt_irq), 16'h0001);
        repeat (20) @(negedge clock);
        chk(16'(status.wt_irq), 16'h0001);
        pulse(5'h08);
        chk(16'(status.wt_irq), 16'h0000);
        step(512, 1'b0, 1'b1);
        chk(16'(status.wt_irq), 16'h0001);
        $display("test watch done");
    endtask
    task t_timebase;
        pulse(5'h11);
        step(4095, 1'b1, 1'b0);
        chk({11'h000, tb_taps, status.tb_irq}, 16'h0000);
        step(1, 1'b1, 1'b0);
        chk(16'(tb_taps), 16'h0001);
        chk(16'(status.tb_irq), 16'h0001);
        chk(16'(status.stab_done), 16'h0000);
        $display("test timebase done");
    endtask
    task t_dog;
        pulse(5'h18);
        cfg.wd_src_watch = 1'b1;
        pulse(5'h04);
        chk(16'(status.wd_active), 16'h0001);
        step(1536, 1'b0, 1'b1);
        pulse(5'h02);
        step(2048, 1'b0, 1'b1);
        chk(16'(reset_count), 16'h0000);
        step(1024, 1'b0, 1'b1);
        chk(16'(status.wd_active), 16'h0001);
        step(1024, 1'b0, 1'b1);
        chk(16'(reset_count), 16'h0001);
        chk(16'(status.wd_active), 16'h0000);
        cfg.wd_src_watch = 1'b0;
        pulse(5'h18);
        pulse(5'h04);
        step(3584, 1'b0, 1'b1);
        chk(16'(reset_count), 16'h0001);
        chk(16'(status.wd_active), 16'h0001);
        $display("test watchdog done");
    endtask
    initial begin
        repeat (3) @(negedge clock);
        reset = 1'b0;
        t_reset;
        t_watch;
        t_timebase;
        t_dog;
        give_verdict;
    end
endmodule // timebase_watch_watchdog_tb

// file: inc/timebase_watch_pkg.sv
// Types shared by the timebase, watch timer and watchdog block.
// Assumes the constants header is compiled alongside.
package timebase_watch_pkg;
    typedef struct packed {
        logic [1:0] tb_interval_sel;
        logic [1:0] wt_interval_sel;
        logic [1:0] wd_tap_sel;
        logic wd_src_watch;
    } timer_cfg_t;
    typedef struct packed {
        logic tb_clear;
        logic wt_clear;
        logic wd_start;
        logic wd_clear;
        logic stab_restart;
    } timer_cmd_t;
    typedef struct packed {
        logic tb_irq;
        logic wt_irq;
        logic stab_done;
        logic wd_active;
        logic cpu_reset;
    } timer_status_t;
    typedef enum logic [1:0] {
        wd_idle = 2'b00,
        wd_run = 2'b01,
        wd_fire = 2'b10
    } wd_state_t;
endpackage

// file: inc/timebase_watch_regs.svh
// Constants for the timebase, watch timer and watchdog block.
// Assumes a single 50 MHz clock domain.
`ifndef TIMEBASE_WATCH_REGS_SVH
`define TIMEBASE_WATCH_REGS_SVH
`define TB_WIDTH 18
`define WT_WIDTH 15
`define WD_WIDTH 2
`define TB_RESET_VALUE 18'h00000
`define WT_RESET_VALUE 15'h0000
`define WD_RESET_VALUE 2'h0
`define TB_TAP0 12
`define TB_TAP1 14
`define TB_TAP2 16
`define TB_TAP3 17
`define WT_TAP0 9
`define WT_TAP1 11
`define WT_TAP2 13
`define WT_TAP3 14
`define TB_STAB_BIT 15
`define CLOCK_NS 20
`define CPU_RESET_NS 80
`define CPU_RESET_CYCLES ((`CPU_RESET_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`endif

// file: logic/tap_flag.sv
// Interval request flag set on a rising tap edge, held until cleared.
// Assumes tap is a registered signal of the same clock.
`timescale 1ns/100ps
module tap_flag (
    input wire logic clock,
    input wire logic reset,
    input wire logic tap,
    input wire logic clear,
    output logic flag
);
    logic tap_ff;
    logic flag_ff;
    always_ff @(posedge clock) begin
        if (reset) begin
            tap_ff <= 1'b0;
        end else begin
            tap_ff <= tap;
        end
    end
    // Set wins over a clear in the same cycle.
    always_ff @(posedge clock) begin
        if (reset) begin
            flag_ff <= 1'b0;
        end else if (tap && !tap_ff) begin
            flag_ff <= 1'b1;
        end else if (clear) begin
            flag_ff <= 1'b0;
        end
    end
    assign flag = flag_ff;
endmodule // tap_flag

// file: logic/timebase_watch_watchdog.sv
// Timebase counter, watch timer and watchdog with their request flags.
// Assumes count clock strobes come from pins and control from the same clock.
//
// Summary of operation
// - Watch timer is a 15-bit counter stepping on the sub clock.
// - Watch timer raises a request each selected interval while running.
// - A setting makes a watch timer tap clock the watchdog instead.
// - Watchdog is a 2-bit counter stepped by timebase or watch tap.
// - Active watchdog resets the CPU unless software clears it in time.
// - Timebase is an 18-bit free-running up counter that wraps.
// - Timebase steps once per count clock at twice base oscillator.
// - Timebase interval request uses one of four selectable taps.
// - Timebase marks the end of the oscillator stabilization wait.
// - Timebase taps are offered as clocks to other timers.
`timescale 1ns/100ps
`include "timebase_watch_regs.svh"
module timebase_watch_watchdog import timebase_watch_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic base_x2_tick,
    input wire logic sub_tick,
    input wire logic sub_run,
    input wire timer_cfg_t cfg,
    input wire timer_cmd_t cmd,
    output timer_status_t status,
    output logic [3:0] tb_taps
);
    logic [2:0] base_sync_ff;
    logic [2:0] sub_sync_ff;
    logic [1:0] run_sync_ff;
    logic [`TB_WIDTH-1:0] tb_cnt_ff;
    logic [`WT_WIDTH-1:0] wt_cnt_ff;
    logic [`WD_WIDTH-1:0] wd_cnt_ff;
    wd_state_t wd_state_ff;
    logic [2:0] rst_cnt_ff;
    logic stab_ff;
    logic wd_tap_prev_ff;
    logic [3:0] tb_taps_ff;
    logic base_step;
    logic sub_step;
    logic tb_sel_tap;
    logic wt_sel_tap;
    logic wd_tap;
    logic wd_step;
    logic tb_flag;
    logic wt_flag;

    function automatic logic pick_tb(input logic [`TB_WIDTH-1:0] c,
                                     input logic [1:0] s);
        unique case (s)
            2'h0: pick_tb = c[`TB_TAP0];
            2'h1: pick_tb = c[`TB_TAP1];
            2'h2: pick_tb = c[`TB_TAP2];
            2'h3: pick_tb = c[`TB_TAP3];
        endcase
    endfunction

    function automatic logic pick_wt(input logic [`WT_WIDTH-1:0] c,
                                     input logic [1:0] s);
        unique case (s)
            2'h0: pick_wt = c[`WT_TAP0];
            2'h1: pick_wt = c[`WT_TAP1];
            2'h2: pick_wt = c[`WT_TAP2];
            2'h3: pick_wt = c[`WT_TAP3];
        endcase
    endfunction

    // Count clock strobes from outside pass two flops before use.
    always_ff @(posedge clock) begin
        if (reset) begin
            base_sync_ff <= 3'h0;
            sub_sync_ff <= 3'h0;
            run_sync_ff <= 2'h0;
        end else begin
            base_sync_ff <= {base_sync_ff[1:0], base_x2_tick};
            sub_sync_ff <= {sub_sync_ff[1:0], sub_tick};
            run_sync_ff <= {run_sync_ff[0], sub_run};
        end
    end
    assign base_step = base_sync_ff[1] && !base_sync_ff[2];
    assign sub_step = sub_sync_ff[1] && !sub_sync_ff[2];

    // Timebase counter wraps at its maximum and reloads zero on a timebase clear.
    always_ff @(posedge clock) begin
        if (reset || cmd.tb_clear) begin
            tb_cnt_ff <= `TB_RESET_VALUE;
        end else if (base_step) begin
            tb_cnt_ff <= tb_cnt_ff + 18'h00001;
        end
    end

    // Watch timer counts sub clock edges while the sub clock runs.
    always_ff @(posedge clock) begin
        if (reset || cmd.wt_clear) begin
            wt_cnt_ff <= `WT_RESET_VALUE;
        end else if (sub_step && run_sync_ff[1]) begin
            wt_cnt_ff <= wt_cnt_ff + 15'h0001;
        end
    end

    assign tb_sel_tap = pick_tb(tb_cnt_ff, cfg.tb_interval_sel);
    assign wt_sel_tap = pick_wt(wt_cnt_ff, cfg.wt_interval_sel);

    tap_flag u_tb_flag (
        .clock(clock),
        .reset(reset),
        .tap(tb_sel_tap),
        .clear(cmd.tb_clear),
        .flag(tb_flag)
    );

    tap_flag u_wt_flag (
        .clock(clock),
        .reset(reset),
        .tap(wt_sel_tap),
        .clear(cmd.wt_clear),
        .flag(wt_flag)
    );

    // Stabilization wait ends when the chosen bit first rises.
    always_ff @(posedge clock) begin
        if (reset) begin
            stab_ff <= 1'b0;
        end else if (tb_cnt_ff[`TB_STAB_BIT]) begin
            stab_ff <= 1'b1;
        end else if (cmd.stab_restart) begin
            stab_ff <= 1'b0;
        end
    end

    // Registered taps for other timers.
    always_ff @(posedge clock) begin
        if (reset) begin
            tb_taps_ff <= 4'h0;
        end else begin
            tb_taps_ff <= {tb_cnt_ff[`TB_TAP3], tb_cnt_ff[`TB_TAP2],
                           tb_cnt_ff[`TB_TAP1], tb_cnt_ff[`TB_TAP0]};
        end
    end

    // Watchdog clock source chosen between timebase and watch taps.
    assign wd_tap = cfg.wd_src_watch ?
                    pick_wt(wt_cnt_ff, cfg.wd_tap_sel) :
                    pick_tb(tb_cnt_ff, cfg.wd_tap_sel);
    always_ff @(posedge clock) begin
        if (reset) begin
            wd_tap_prev_ff <= 1'b0;
        end else begin
            wd_tap_prev_ff <= wd_tap;
        end
    end
    assign wd_step = wd_tap && !wd_tap_prev_ff;

    // Watchdog control; once started it runs until a reset.
    always_ff @(posedge clock) begin
        if (reset) begin
            wd_state_ff <= wd_idle;
        end else begin
            unique case (wd_state_ff)
                wd_idle: begin
                    if (cmd.wd_start) begin
                        wd_state_ff <= wd_run;
                    end
                end
                wd_run: begin
                    if (wd_step && !cmd.wd_clear && wd_cnt_ff == 2'h3) begin
                        wd_state_ff <= wd_fire;
                    end
                end
                wd_fire: begin
                    if (rst_cnt_ff == 3'(`CPU_RESET_CYCLES - 1)) begin
                        wd_state_ff <= wd_idle;
                    end
                end
                default: wd_state_ff <= wd_idle;
            endcase
        end
    end

    // Two-bit count, zeroed by a software clear.
    always_ff @(posedge clock) begin
        if (reset || wd_state_ff != wd_run || cmd.wd_clear) begin
            wd_cnt_ff <= `WD_RESET_VALUE;
        end else if (wd_step) begin
            wd_cnt_ff <= wd_cnt_ff + 2'h1;
        end
    end

    // Length of the CPU reset pulse.
    always_ff @(posedge clock) begin
        if (reset || wd_state_ff != wd_fire) begin
            rst_cnt_ff <= 3'h0;
        end else begin
            rst_cnt_ff <= rst_cnt_ff + 3'h1;
        end
    end

    assign status.tb_irq = tb_flag;
    assign status.wt_irq = wt_flag;
    assign status.stab_done = stab_ff;
    assign status.wd_active = (wd_state_ff == wd_run);
    assign status.cpu_reset = (wd_state_ff == wd_fire);
    assign tb_taps = tb_taps_ff;
endmodule // timebase_watch_watchdog
